// file: hw/cbs_consts.svh
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

// flag register bit positions
`define CBS_FLAG_C 0
`define CBS_FLAG_V 1
`define CBS_FLAG_Z 2
`define CBS_FLAG_N 3

// branch condition codes
`define CBS_COND_ALWAYS 4'h0
`define CBS_COND_NEVER  4'h1
`define CBS_COND_HI     4'h2
`define CBS_COND_LS     4'h3
`define CBS_COND_CC     4'h4
`define CBS_COND_CS     4'h5
`define CBS_COND_NE     4'h6
`define CBS_COND_EQ     4'h7
`define CBS_COND_VC     4'h8
`define CBS_COND_VS     4'h9
`define CBS_COND_PL     4'hA
`define CBS_COND_MI     4'hB
`define CBS_COND_GE     4'hC
`define CBS_COND_LT     4'hD
`define CBS_COND_GT     4'hE
`define CBS_COND_LE     4'hF

// reset values and program counter step of the idle operation
`define CBS_FLAGS_RESET 8'h80
`define CBS_PC_RESET    24'h000000
`define CBS_IDLE_STEP   24'h000002
`define CBS_SP_RESET    3'h0
`define CBS_STACK_DEPTH 8

// byte lane that holds the flag register in a word transfer
`define CBS_WORD_FLAG_HI 15
`define CBS_WORD_FLAG_LO 8
`define CBS_WORD_PAD     8'h00

// software register offsets
`define CBS_RA_FLAGS   3'h0
`define CBS_RA_STATUS  3'h1
`define CBS_RA_CONTROL 3'h2
`define CBS_RA_PC_LO   3'h3
`define CBS_RA_PC_MID  3'h4
`define CBS_RA_PC_HI   3'h5

// status and control bit positions
`define CBS_ST_SLEEP_BIT 0
`define CBS_ST_BUSY_BIT  1
`define CBS_CTL_WAKE_BIT 0

`endif

// file: hw/cbs_pkg.sv
package cbs_pkg;

  // operations handed over by the decoder
  typedef enum logic [4:0] {
    OP_IDLE         = 5'b00000,
    OP_LOAD_BIT     = 5'b00001,
    OP_LOAD_INV_BIT = 5'b00010,
    OP_STORE_BIT    = 5'b00011,
    OP_STORE_INV    = 5'b00100,
    OP_COND_BRANCH  = 5'b00101,
    OP_JUMP         = 5'b00110,
    OP_CALL_REL     = 5'b00111,
    OP_CALL_ABS     = 5'b01000,
    OP_SUB_RETURN   = 5'b01001,
    OP_SW_TRAP      = 5'b01010,
    OP_EXC_RETURN   = 5'b01011,
    OP_SLEEP        = 5'b01100,
    OP_LOAD_FLAGS   = 5'b01101,
    OP_SAVE_FLAGS   = 5'b01110,
    OP_FLAGS_AND    = 5'b01111,
    OP_FLAGS_OR     = 5'b10000,
    OP_FLAGS_XOR    = 5'b10001
  } cbs_op_t;

  // execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_SLEEP = 2'b11
  } cbs_state_t;

endpackage

// file: hw/cbs_cond_eval.sv
`timescale 1ns/100ps
`default_nettype none
`include "cbs_consts.svh"

module cbs_cond_eval (
  // flags and condition
  input  wire logic [7:0] flags,
  input  wire logic [3:0] cond,
  // verdict
  output logic            taken
);

  logic c;
  logic v;
  logic z;
  logic n;

  // flag picks
  assign c = flags[`CBS_FLAG_C];
  assign v = flags[`CBS_FLAG_V];
  assign z = flags[`CBS_FLAG_Z];
  assign n = flags[`CBS_FLAG_N];

  // condition table
  always_comb begin
    case (cond)
      `CBS_COND_ALWAYS: taken = 1'b1;
      `CBS_COND_NEVER:  taken = 1'b0;
      `CBS_COND_HI:     taken = ~(c | z);
      `CBS_COND_LS:     taken = c | z;
      `CBS_COND_CC:     taken = ~c;
      `CBS_COND_CS:     taken = c;
      `CBS_COND_NE:     taken = ~z;
      `CBS_COND_EQ:     taken = z;
      `CBS_COND_VC:     taken = ~v;
      `CBS_COND_VS:     taken = v;
      `CBS_COND_PL:     taken = ~n;
      `CBS_COND_MI:     taken = n;
      `CBS_COND_GE:     taken = ~(n ^ v);
      `CBS_COND_LT:     taken = n ^ v;
      `CBS_COND_GT:     taken = ~(z | (n ^ v));
      default:          taken = z | (n ^ v);
    endcase
  end

endmodule
`default_nettype wire

// file: hw/cbs_exec.sv
// Notes on behaviour
// - load bit to carry copies the chosen operand bit into carry
// - inverted load puts the complement of the chosen bit into carry
// - inverted load and store take the bit number from a 3-bit immediate
// - store carry to bit writes carry into the chosen operand bit
// - inverted store writes the complement of carry into the chosen bit
// - conditional branch taken only when condition holds; always and never variants
// - unsigned tests: higher, lower-or-same from C or Z; carry clear and set
// - zero, overflow, negative tests; signed tests from N xor V and Z
// - software trap starts trap exception handling
// - exception return resumes at the saved point
// - sleep moves the processor into power-down
// - loading flags from memory uses a word read, keeping one byte
// - saving flags to memory uses a word write
// - flags AND immediate replaces flags with the bitwise AND
// - flags OR immediate replaces flags with the bitwise OR
// - flags XOR immediate replaces flags with the bitwise XOR
// - idle operation only advances the program counter by two
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_consts.svh"

module cbs_exec (
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // decoded operation
  input  wire logic             opValid,
  output logic                  opReady,
  input  wire cbs_pkg::cbs_op_t opCode,
  input  wire logic [2:0]       opBitNum,
  input  wire logic [7:0]       opImm,
  input  wire logic [3:0]       opCond,
  input  wire logic             opUseMem,
  input  wire logic [23:0]      opAddr,
  input  wire logic [23:0]      opTarget,
  input  wire logic [7:0]       opRegByte,
  input  wire logic [3:0]       opLen,
  // general register write back
  output logic                  gprWrEn,
  output logic [7:0]            gprWrData,
  // memory port
  output logic                  memReq,
  output logic                  memWe,
  output logic                  memWord,
  output logic [23:0]           memAddr,
  output logic [15:0]           memWdata,
  input  wire logic [15:0]      memRdata,
  input  wire logic             memAck,
  // exception sequencer
  output logic                  trapStart,
  output logic [23:0]           trapReturnPc,
  output logic                  excRetStart,
  input  wire logic [23:0]      excPcIn,
  input  wire logic [7:0]       excFlagsIn,
  // power and state
  input  wire logic             wakePin,
  output logic                  sleeping,
  output logic                  branchTaken,
  output logic [23:0]           pc,
  output logic [7:0]            flags,
  // software port
  input  wire logic [2:0]       swAddr,
  input  wire logic [7:0]       swWdata,
  input  wire logic             swWr,
  input  wire logic             swRd,
  output logic [7:0]            swRdata
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic bitOf(input logic [7:0] b, input logic [2:0] idx);
    bitOf = b[idx];
  endfunction

  function automatic logic [7:0] putBit(input logic [7:0] b, input logic [2:0] idx,
                                        input logic val);
    logic [7:0] r;
    r = b;
    r[idx] = val;
    putBit = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  cbs_pkg::cbs_state_t state_q, state_d;
  cbs_pkg::cbs_op_t    pendOp_q, pendOp_d;
  logic [2:0]          pendBit_q, pendBit_d;
  logic [23:0]         pc_q, pc_d;
  logic [7:0]          flags_q, flags_d;
  logic [2:0]          sp_q, sp_d;
  logic [23:0]         retStack [`CBS_STACK_DEPTH];
  logic                push;
  logic [23:0]         pushPc;
  logic                gprWrEn_q, gprWrEn_d;
  logic [7:0]          gprWrData_q, gprWrData_d;
  logic                memReq_q, memReq_d;
  logic                memWe_q, memWe_d;
  logic                memWord_q, memWord_d;
  logic [23:0]         memAddr_q, memAddr_d;
  logic [15:0]         memWdata_q, memWdata_d;
  logic                trapStart_q, trapStart_d;
  logic [23:0]         trapPc_q, trapPc_d;
  logic                excRet_q, excRet_d;
  logic                taken_q, taken_d;
  logic [7:0]          swRdata_q, swRdata_d;
  logic                wakeMeta_q;
  logic                wakeSync_q;
  logic                condTrue;
  logic                issue;
  logic [23:0]         pcStep;
  logic                carry;
  logic                insnFlags;
  logic                srcBit;
  logic [7:0]          storeByte;
  logic [7:0]          storeInvByte;

  cbs_cond_eval u_cond (
    .flags (flags_q),
    .cond  (opCond),
    .taken (condTrue)
  );

  // handshake and shared terms
  assign opReady      = (state_q == cbs_pkg::ST_IDLE);
  assign issue        = ce & opValid & opReady;
  assign pcStep       = pc_q + {20'h00000, opLen};
  assign carry        = flags_q[`CBS_FLAG_C];
  assign srcBit       = bitOf(opRegByte, opBitNum);
  assign storeByte    = putBit(opRegByte, opBitNum, carry);
  assign storeInvByte = putBit(opRegByte, opBitNum, ~carry);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d     = state_q;
    pendOp_d    = pendOp_q;
    pendBit_d   = pendBit_q;
    pc_d        = pc_q;
    flags_d     = flags_q;
    sp_d        = sp_q;
    push        = 1'b0;
    pushPc      = pcStep;
    gprWrEn_d   = 1'b0;
    gprWrData_d = gprWrData_q;
    memReq_d    = memReq_q;
    memWe_d     = memWe_q;
    memWord_d   = memWord_q;
    memAddr_d   = memAddr_q;
    memWdata_d  = memWdata_q;
    trapStart_d = 1'b0;
    trapPc_d    = trapPc_q;
    excRet_d    = 1'b0;
    taken_d     = 1'b0;
    insnFlags   = 1'b0;
    case (state_q)
      cbs_pkg::ST_IDLE: begin
        if (issue) begin
          pendOp_d  = opCode;
          pendBit_d = opBitNum;
          pc_d      = pcStep;
          memAddr_d = opAddr;
          case (opCode)
            cbs_pkg::OP_LOAD_BIT, cbs_pkg::OP_LOAD_INV_BIT: begin
              if (opUseMem) begin
                memReq_d  = 1'b1;
                memWe_d   = 1'b0;
                memWord_d = 1'b0;
                state_d   = cbs_pkg::ST_READ;
              end else begin
                insnFlags = 1'b1;
                flags_d[`CBS_FLAG_C] = (opCode == cbs_pkg::OP_LOAD_BIT) ? srcBit
                                                                         : ~srcBit;
              end
            end
            cbs_pkg::OP_STORE_BIT, cbs_pkg::OP_STORE_INV: begin
              if (opUseMem) begin
                memReq_d  = 1'b1;                           // read half of read-modify-write
                memWe_d   = 1'b0;
                memWord_d = 1'b0;
                state_d   = cbs_pkg::ST_READ;
              end else begin
                gprWrEn_d   = 1'b1;
                gprWrData_d = (opCode == cbs_pkg::OP_STORE_BIT) ? storeByte
                                                                : storeInvByte;
              end
            end
            cbs_pkg::OP_COND_BRANCH: begin
              taken_d = condTrue;
              if (condTrue) begin
                pc_d = opTarget;
              end
            end
            cbs_pkg::OP_JUMP: pc_d = opTarget;
            cbs_pkg::OP_CALL_REL, cbs_pkg::OP_CALL_ABS: begin
              push = 1'b1;
              sp_d = sp_q + 3'h1;
              pc_d = opTarget;
            end
            cbs_pkg::OP_SUB_RETURN: begin
              sp_d = sp_q - 3'h1;
              pc_d = retStack[sp_q - 3'h1];
            end
            cbs_pkg::OP_SW_TRAP: begin
              trapStart_d = 1'b1;
              trapPc_d    = pcStep;
            end
            cbs_pkg::OP_EXC_RETURN: begin
              excRet_d  = 1'b1;
              pc_d      = excPcIn;
              flags_d   = excFlagsIn;
              insnFlags = 1'b1;
            end
            cbs_pkg::OP_SLEEP: state_d = cbs_pkg::ST_SLEEP;
            cbs_pkg::OP_LOAD_FLAGS: begin
              if (opUseMem) begin
                memReq_d  = 1'b1;
                memWe_d   = 1'b0;
                memWord_d = 1'b1;
                state_d   = cbs_pkg::ST_READ;
              end else begin
                flags_d   = opRegByte;
                insnFlags = 1'b1;
              end
            end
            cbs_pkg::OP_SAVE_FLAGS: begin
              if (opUseMem) begin
                memReq_d   = 1'b1;
                memWe_d    = 1'b1;
                memWord_d  = 1'b1;
                memWdata_d = {flags_q, `CBS_WORD_PAD};
                state_d    = cbs_pkg::ST_WRITE;
              end else begin
                gprWrEn_d   = 1'b1;
                gprWrData_d = flags_q;
              end
            end
            cbs_pkg::OP_FLAGS_AND: begin
              flags_d   = flags_q & opImm;
              insnFlags = 1'b1;
            end
            cbs_pkg::OP_FLAGS_OR: begin
              flags_d   = flags_q | opImm;
              insnFlags = 1'b1;
            end
            cbs_pkg::OP_FLAGS_XOR: begin
              flags_d   = flags_q ^ opImm;
              insnFlags = 1'b1;
            end
            default: pc_d = pc_q + `CBS_IDLE_STEP;
          endcase
        end
      end
      cbs_pkg::ST_READ: begin
        if (memAck) begin
          memReq_d = 1'b0;
          state_d  = cbs_pkg::ST_IDLE;
          case (pendOp_q)
            cbs_pkg::OP_LOAD_BIT: begin
              flags_d[`CBS_FLAG_C] = bitOf(memRdata[7:0], pendBit_q);
              insnFlags = 1'b1;
            end
            cbs_pkg::OP_LOAD_INV_BIT: begin
              flags_d[`CBS_FLAG_C] = ~bitOf(memRdata[7:0], pendBit_q);
              insnFlags = 1'b1;
            end
            cbs_pkg::OP_STORE_BIT, cbs_pkg::OP_STORE_INV: begin
              memReq_d   = 1'b1;
              memWe_d    = 1'b1;
              memWdata_d = {`CBS_WORD_PAD, putBit(memRdata[7:0], pendBit_q,
                            (pendOp_q == cbs_pkg::OP_STORE_BIT) ? carry : ~carry)};
              state_d    = cbs_pkg::ST_WRITE;
            end
            default: begin
              flags_d   = memRdata[`CBS_WORD_FLAG_HI:`CBS_WORD_FLAG_LO];
              insnFlags = 1'b1;
            end
          endcase
        end
      end
      cbs_pkg::ST_WRITE: begin
        if (memAck) begin
          memReq_d = 1'b0;
          memWe_d  = 1'b0;
          state_d  = cbs_pkg::ST_IDLE;
        end
      end
      default: begin
        if (wakeSync_q || (swWr && swAddr == `CBS_RA_CONTROL && swWdata[`CBS_CTL_WAKE_BIT])) begin
          state_d = cbs_pkg::ST_IDLE;
        end
      end
    endcase
    // software flag write loses to an instruction that writes the flags in the same cycle
    if (swWr && swAddr == `CBS_RA_FLAGS && !insnFlags) begin
      flags_d = swWdata;
    end
  end

  // software read decode
  always_comb begin
    swRdata_d = 8'h00;
    if (!swRd) begin
      swRdata_d = 8'h00;
    end else if (swAddr == `CBS_RA_FLAGS) begin
      swRdata_d = flags_q;
    end else if (swAddr == `CBS_RA_STATUS) begin
      swRdata_d[`CBS_ST_SLEEP_BIT] = (state_q == cbs_pkg::ST_SLEEP);
      swRdata_d[`CBS_ST_BUSY_BIT]  = memReq_q;
    end else if (swAddr == `CBS_RA_PC_LO) begin
      swRdata_d = pc_q[7:0];
    end else if (swAddr == `CBS_RA_PC_MID) begin
      swRdata_d = pc_q[15:8];
    end else if (swAddr == `CBS_RA_PC_HI) begin
      swRdata_d = pc_q[23:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= cbs_pkg::ST_IDLE;
      pendOp_q    <= cbs_pkg::OP_IDLE;
      pendBit_q   <= 3'h0;
      pc_q        <= `CBS_PC_RESET;
      flags_q     <= `CBS_FLAGS_RESET;
      sp_q        <= `CBS_SP_RESET;
      gprWrEn_q   <= 1'b0;
      gprWrData_q <= 8'h00;
      memReq_q    <= 1'b0;
      memWe_q     <= 1'b0;
      memWord_q   <= 1'b0;
      memAddr_q   <= 24'h000000;
      memWdata_q  <= 16'h0000;
      trapStart_q <= 1'b0;
      trapPc_q    <= 24'h000000;
      excRet_q    <= 1'b0;
      taken_q     <= 1'b0;
      swRdata_q   <= 8'h00;
      wakeMeta_q  <= 1'b0;
      wakeSync_q  <= 1'b0;
    end else if (ce) begin
      state_q     <= state_d;
      pendOp_q    <= pendOp_d;
      pendBit_q   <= pendBit_d;
      pc_q        <= pc_d;
      flags_q     <= flags_d;
      sp_q        <= sp_d;
      gprWrEn_q   <= gprWrEn_d;
      gprWrData_q <= gprWrData_d;
      memReq_q    <= memReq_d;
      memWe_q     <= memWe_d;
      memWord_q   <= memWord_d;
      memAddr_q   <= memAddr_d;
      memWdata_q  <= memWdata_d;
      trapStart_q <= trapStart_d;
      trapPc_q    <= trapPc_d;
      excRet_q    <= excRet_d;
      taken_q     <= taken_d;
      swRdata_q   <= swRdata_d;
      wakeMeta_q  <= wakePin;
      wakeSync_q  <= wakeMeta_q;
    end
  end

  // return address stack, no reset needed
  always_ff @(posedge clk) begin
    if (ce && push) begin
      retStack[sp_q] <= pushPc;
    end
  end

  // outputs
  assign gprWrEn      = gprWrEn_q;
  assign gprWrData    = gprWrData_q;
  assign memReq       = memReq_q;
  assign memWe        = memWe_q;
  assign memWord      = memWord_q;
  assign memAddr      = memAddr_q;
  assign memWdata     = memWdata_q;
  assign trapStart    = trapStart_q;
  assign trapReturnPc = trapPc_q;
  assign excRetStart  = excRet_q;
  assign sleeping     = (state_q == cbs_pkg::ST_SLEEP);
  assign branchTaken  = taken_q;
  assign pc           = pc_q;
  assign flags        = flags_q;
  assign swRdata      = swRdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_idle_pc_step: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_IDLE && !swWr |=> pc_q == $past(pc_q) + `CBS_IDLE_STEP
      && flags_q == $past(flags_q) && !memReq_q && !gprWrEn_q) else $error("idle op step wrong");
  a_load_bit_carry: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_LOAD_BIT && !opUseMem
      |=> flags_q[`CBS_FLAG_C] == $past(srcBit)) else $error("load bit carry wrong");
  a_inv_load_carry: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_LOAD_INV_BIT && !opUseMem
      |=> flags_q[`CBS_FLAG_C] != $past(srcBit)) else $error("inverted load wrong");
  a_store_bit_reg: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_STORE_BIT && !opUseMem
      |=> gprWrEn_q && gprWrData_q == $past(storeByte)) else $error("store bit wrong");
  a_inv_store_reg: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_STORE_INV && !opUseMem
      |=> gprWrEn_q && gprWrData_q == $past(storeInvByte)) else $error("inverted store wrong");
  a_branch_target: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_COND_BRANCH
      |=> pc_q == ($past(condTrue) ? $past(opTarget) : $past(pcStep))) else $error("branch pc wrong");
  a_flags_word_read: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_LOAD_FLAGS && opUseMem
      |=> memReq_q && !memWe_q && memWord_q) else $error("flag load not word read");
  a_flags_word_write: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_SAVE_FLAGS && opUseMem
      |=> memReq_q && memWe_q && memWord_q) else $error("flag save not word write");
  a_flags_and_imm: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_FLAGS_AND
      |=> flags_q == ($past(flags_q) & $past(opImm))) else $error("flag and wrong");
  a_flags_xor_imm: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_FLAGS_XOR
      |=> flags_q == ($past(flags_q) ^ $past(opImm))) else $error("flag xor wrong");
  a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_SLEEP |=> sleeping && !opReady) else $error("no sleep");
  a_trap_pulse: assert property (@(posedge clk) disable iff (rst)
    issue && opCode == cbs_pkg::OP_SW_TRAP |=> trapStart_q && trapPc_q == $past(pcStep))
    else $error("trap not started");

endmodule
`default_nettype wire

// file: test/cbs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module cbs_mem_model (
  // clock and pacing
  input  wire logic        clk,
  input  wire logic [3:0]  waitCycles,
  // memory port
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic        memWord,
  input  wire logic [23:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic [15:0]      memRdata,
  output logic             memAck
);
  logic [7:0] mem [0:255];
  logic [3:0] cntQ = 4'h0;
  logic [7:0] a;
  assign a = memAddr[7:0];
  // idle read data is not zero, so a late sample shows up
  initial begin
    memRdata = 16'h5AA5;
    memAck = 1'b0;
  end
  // answer after waitCycles (1 or more); read data toggle unless a read is answered
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    cntQ <= memReq ? cntQ + 4'h1 : 4'h0;
    if (memReq && cntQ == waitCycles) begin
      memAck <= 1'b1;
      cntQ <= 4'h0;
      if (memWe && memWord) begin
        mem[a] <= memWdata[15:8];
        mem[a + 8'h01] <= memWdata[7:0];
      end else if (memWe) begin
        mem[a] <= memWdata[7:0];
      end else begin
        memRdata <= memWord ? {mem[a], mem[a + 8'h01]} : {~mem[a], mem[a]};
      end
    end
  end
endmodule
`default_nettype wire

// file: test/cbs_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cbs_consts.svh"

module cbs_exec_tb;
  // driven inputs
  logic             clk = 1'b0, rst = 1'b1, ce = 1'b1, opValid = 1'b0, opUseMem = 1'b0;
  logic             wakePin = 1'b0, swWr = 1'b0, swRd = 1'b0;
  cbs_pkg::cbs_op_t opCode = cbs_pkg::OP_IDLE;
  logic [2:0]       opBitNum = 3'h0, swAddr = 3'h0;
  logic [7:0]       opImm = 8'h00, excFlagsIn = 8'h00, swWdata = 8'h00;
  logic [23:0]      opAddr = 24'h000000, excPcIn = 24'h000000;
  logic [3:0]       opLen = 4'h2, memWait = 4'h1;
  // observed outputs
  logic             opReady, gprWrEn, memReq, memWe, memWord, memAck;
  logic             trapStart, excRetStart, sleeping, branchTaken;
  logic [7:0]       gprWrData, flags, swRdata;
  logic [15:0]      memWdata, memRdata;
  logic [23:0]      memAddr, trapReturnPc, pc, expPc = 24'h000000, rtA, rtB;
  logic [7:0]       expFl = 8'h80;
  int               error_cnt = 0, compares = 0, cyc = 0;

  always #4 clk = ~clk;
  cbs_exec dut_u (.clk(clk), .rst(rst), .ce(ce), .opValid(opValid), .opReady(opReady),
    .opCode(opCode), .opBitNum(opBitNum), .opImm(opImm), .opCond(opImm[3:0]),
    .opUseMem(opUseMem), .opAddr(opAddr), .opTarget(opAddr), .opRegByte(opImm),
    .opLen(opLen), .gprWrEn(gprWrEn), .gprWrData(gprWrData), .memReq(memReq),
    .memWe(memWe), .memWord(memWord), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .trapStart(trapStart),
    .trapReturnPc(trapReturnPc), .excRetStart(excRetStart), .excPcIn(excPcIn),
    .excFlagsIn(excFlagsIn), .wakePin(wakePin), .sleeping(sleeping),
    .branchTaken(branchTaken), .pc(pc), .flags(flags), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
  cbs_mem_model mem_u (.clk(clk), .waitCycles(memWait), .memReq(memReq), .memWe(memWe),
    .memWord(memWord), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic st;
    chk("pc", expPc, pc);
    chk("flags", {16'h0000, expFl}, {16'h0000, flags});
  endtask
  // offer one operation while idle, then wait for idle or sleep
  task automatic op(input cbs_pkg::cbs_op_t c, input logic [7:0] v, input logic [2:0] b,
                    input logic m, input logic [23:0] ad, input logic [3:0] n);
    int k;
    k = 0;
    @(posedge clk);
    opValid <= 1'b1;
    opCode <= c;
    opImm <= v;
    opBitNum <= b;
    opUseMem <= m;
    opAddr <= ad;
    opLen <= n;
    @(posedge clk);
    opValid <= 1'b0;
    expPc = expPc + {20'h00000, n};
    @(negedge clk);
    while ((opReady | sleeping) !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("done", 24'h1, {23'h0, opReady | sleeping});
  endtask
  task automatic fop(input cbs_pkg::cbs_op_t c, input logic [7:0] v, input logic [7:0] e);
    op(c, v, 3'h0, 1'b0, 24'h000000, 4'h2);
    expFl = e;
    st();
  endtask
  // software port: one strobe cycle, read data in the next cycle only
  task automatic sw(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    swWr <= w;
    swRd <= !w;
    swAddr <= a;
    swWdata <= d;
    @(posedge clk);
    swWr <= 1'b0;
    swRd <= 1'b0;
    @(negedge clk);
    if (!w) chk("swRdata", {16'h0000, d}, {16'h0000, swRdata});
  endtask
  function automatic logic taken(input logic [3:0] c, input logic [3:0] f);
    logic [7:0] t;
    t = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
    return t[c[3:1]] ^ !c[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    mem_u.mem[8'h10] = 8'hA5;
    mem_u.mem[8'h21] = 8'hFF;
    mem_u.mem[8'h30] = 8'h4A;
    mem_u.mem[8'h31] = 8'h35;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    st();
    fop(cbs_pkg::OP_FLAGS_OR, 8'h0F, 8'h8F);
    fop(cbs_pkg::OP_FLAGS_AND, 8'hF5, 8'h85);
    fop(cbs_pkg::OP_FLAGS_XOR, 8'h07, 8'h82);
    op(cbs_pkg::OP_LOAD_BIT, 8'h20, 3'h5, 1'b0, 24'h000000, 4'h2);
    expFl = 8'h83;
    st();
    op(cbs_pkg::OP_LOAD_INV_BIT, 8'h20, 3'h5, 1'b0, 24'h000000, 4'h2);
    expFl = 8'h82;
    st();
    op(cbs_pkg::OP_STORE_INV, 8'h00, 3'h6, 1'b0, 24'h000000, 4'h2);
    chk("gprWr", 24'h000140, {15'h0000, gprWrEn, gprWrData});
    op(cbs_pkg::OP_STORE_BIT, 8'hFF, 3'h3, 1'b0, 24'h000000, 4'h2);
    chk("gprWr", 24'h0001F7, {15'h0000, gprWrEn, gprWrData});
    memWait <= 4'h5;
    op(cbs_pkg::OP_STORE_INV, 8'h00, 3'h1, 1'b1, 24'h000010, 4'h4);
    chk("mem10", 24'h0000A7, {16'h0000, mem_u.mem[8'h10]});
    op(cbs_pkg::OP_LOAD_BIT, 8'h00, 3'h1, 1'b1, 24'h000010, 4'h4);
    expFl = 8'h83;
    st();
    op(cbs_pkg::OP_SAVE_FLAGS, 8'h00, 3'h0, 1'b1, 24'h000020, 4'h4);
    chk("mem20", 24'h008300, {8'h00, mem_u.mem[8'h20], mem_u.mem[8'h21]});
    memWait <= 4'h1;
    op(cbs_pkg::OP_LOAD_FLAGS, 8'h00, 3'h0, 1'b1, 24'h000030, 4'h4);
    expFl = 8'h4A;
    st();
    for (int f = 0; f < 16; f++) begin
      for (int c = 0; c < 16; c++) begin
        fop(cbs_pkg::OP_FLAGS_AND, 8'h00, 8'h00);
        fop(cbs_pkg::OP_FLAGS_OR, f[7:0], f[7:0]);
        op(cbs_pkg::OP_COND_BRANCH, c[7:0], 3'h0, 1'b0, 24'h000400, 4'h4);
        if (taken(c[3:0], f[3:0])) expPc = 24'h000400;
        chk("branchTaken", {23'h0, taken(c[3:0], f[3:0])}, {23'h0, branchTaken});
        st();
      end
    end
    op(cbs_pkg::OP_CALL_ABS, 8'h00, 3'h0, 1'b0, 24'h001000, 4'h4);
    rtA = expPc;
    expPc = 24'h001000;
    op(cbs_pkg::OP_CALL_REL, 8'h00, 3'h0, 1'b0, 24'h002000, 4'h2);
    rtB = expPc;
    op(cbs_pkg::OP_JUMP, 8'h00, 3'h0, 1'b0, 24'h003000, 4'h4);
    expPc = 24'h003000;
    st();
    op(cbs_pkg::OP_SUB_RETURN, 8'h00, 3'h0, 1'b0, 24'h000000, 4'h2);
    expPc = rtB;
    st();
    op(cbs_pkg::OP_SUB_RETURN, 8'h00, 3'h0, 1'b0, 24'h000000, 4'h2);
    expPc = rtA;
    st();
    op(cbs_pkg::OP_IDLE, 8'hFF, 3'h7, 1'b0, 24'h00FFFF, 4'h6);
    expPc = expPc - 24'h000004;
    st();
    op(cbs_pkg::OP_SW_TRAP, 8'h00, 3'h0, 1'b0, 24'h000000, 4'h2);
    chk("trapStart", 24'h000001, {23'h0, trapStart});
    chk("trapReturnPc", expPc, trapReturnPc);
    @(posedge clk);
    excPcIn <= 24'h00ABCC;
    excFlagsIn <= 8'h13;
    op(cbs_pkg::OP_EXC_RETURN, 8'h00, 3'h0, 1'b0, 24'h000000, 4'h2);
    chk("excRetStart", 24'h000001, {23'h0, excRetStart});
    expPc = 24'h00ABCC;
    expFl = 8'h13;
    st();
    sw(1'b0, `CBS_RA_FLAGS, 8'h13);
    sw(1'b0, `CBS_RA_PC_LO, 8'hCC);
    sw(1'b1, `CBS_RA_FLAGS, 8'h55);
    sw(1'b0, `CBS_RA_FLAGS, 8'h55);
    sw(1'b0, 3'h6, 8'h00);
    op(cbs_pkg::OP_SLEEP, 8'h00, 3'h0, 1'b0, 24'h000000, 4'h2);
    chk("sleepReady", 24'h000002, {22'h0, sleeping, opReady});
    @(posedge clk);
    wakePin <= 1'b1;
    repeat (5) @(negedge clk);
    chk("sleeping", 24'h000000, {23'h0, sleeping});
    wakePin <= 1'b0;
    op(cbs_pkg::OP_SLEEP, 8'h00, 3'h0, 1'b0, 24'h000000, 4'h2);
    sw(1'b0, `CBS_RA_STATUS, 8'h01);
    sw(1'b1, `CBS_RA_CONTROL, 8'h01);
    chk("sleeping", 24'h000000, {23'h0, sleeping});
    stop_test();
  end
endmodule
`default_nettype wire
